/* File: hw/tcs_pkg.sv */
`default_nettype none
package tcs_pkg;
	// Register addresses on the special-function-register port
	localparam logic [7:0] ADDR_TMODE    = 8'h89;
	localparam logic [7:0] ADDR_TCTRL    = 8'h88;
	localparam logic [7:0] ADDR_T0_LOW   = 8'h8A;
	localparam logic [7:0] ADDR_T1_LOW   = 8'h8B;
	localparam logic [7:0] ADDR_T0_HIGH  = 8'h8C;
	localparam logic [7:0] ADDR_T1_HIGH  = 8'h8D;
	localparam logic [7:0] ADDR_PRESCALE = 8'h8E;
	localparam logic [7:0] ADDR_T2CTRL   = 8'hC8;
	localparam logic [7:0] ADDR_CAP_LOW  = 8'hCA;
	localparam logic [7:0] ADDR_CAP_HIGH = 8'hCB;
	localparam logic [7:0] ADDR_T2_LOW   = 8'hCC;
	localparam logic [7:0] ADDR_T2_HIGH  = 8'hCD;
	localparam logic [7:0] RESET_VALUE   = 8'h00;
	// Mode register fields
	localparam int T1_GATE_BIT = 7;
	localparam int T1_CT_BIT   = 6;
	localparam int T1_MODE_LSB = 4;
	localparam int T0_GATE_BIT = 3;
	localparam int T0_CT_BIT   = 2;
	localparam int T0_MODE_LSB = 0;
	// Timer control fields
	localparam int TF1_BIT = 7;
	localparam int TR1_BIT = 6;
	localparam int TF0_BIT = 5;
	localparam int TR0_BIT = 4;
	// Prescale control fields
	localparam int T0_CLKSEL_BIT = 3;
	localparam int T1_CLKSEL_BIT = 4;
	localparam int T2_CLKSEL_BIT = 5;
	// Timer 2 control fields
	localparam int TF2_BIT   = 7;
	localparam int TIMER2_EXTERNAL_FLAG_BIT  = 6;
	localparam int RCLK_BIT  = 5;
	localparam int TRANSMIT_BAUD_SELECT_BIT  = 4;
	localparam int TIMER2_EXTERNAL_ENABLE_BIT = 3;
	localparam int TR2_BIT   = 2;
	localparam int CT2_BIT   = 1;
	localparam int CPRL_BIT  = 0;
	// Mode codes for timers 0 and 1
	localparam logic [1:0] MODE_13BIT  = 2'b00;
	localparam logic [1:0] MODE_16BIT  = 2'b01;
	localparam logic [1:0] MODE_RELOAD = 2'b10;
	localparam logic [1:0] MODE_SPLIT  = 2'b11;
	localparam logic [4:0] LOW5_ONES   = 5'h1_F;
	localparam logic [7:0] BYTE_ONES   = 8'hFF;
	localparam logic [3:0] PRESC_LAST  = 4'hB;
	localparam int         PIN_COUNT   = 6;

	typedef struct packed {
		logic       ovf;
		logic [7:0] low;
		logic [7:0] high;
	} tcs_step_s;

	typedef struct packed {
		logic [7:0] tmode;
		logic [7:0] tctrl;
		logic [7:0] prescale;
		logic [7:0] t2ctrl;
		logic [7:0] t0_low;
		logic [7:0] t0_high;
		logic [7:0] t1_low;
		logic [7:0] t1_high;
		logic [7:0] t2_low;
		logic [7:0] t2_high;
		logic [7:0] cap_low;
		logic [7:0] cap_high;
		logic [3:0] presc_cnt;
		logic [7:0] rdata;
		logic       baud_tick;
		logic       adc_trig;
	} tcs_state_s;
endpackage : tcs_pkg
`default_nettype wire

/* File: hw/tcs_pin_sync.sv */
`default_nettype none
module tcs_pin_sync (
	input  wire logic sys_clk,
	input  wire logic reset,
	input  wire logic pin,
	output logic      level,
	output logic      fall
);
	logic meta_reg;
	logic level_reg;
	logic prev_reg;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			meta_reg  <= 1'b1;
			level_reg <= 1'b1;
			prev_reg  <= 1'b1;
		end else begin
			meta_reg  <= pin;
			level_reg <= meta_reg;
			prev_reg  <= level_reg;
		end
	end

	assign level = level_reg;
	// High sample then low sample
	assign fall  = prev_reg & ~level_reg;
endmodule : tcs_pin_sync
`default_nettype wire

/* File: hw/tcs_timers.sv */
// Function
// - Auto-reload: low byte counts, high byte holds the reload value.
// - Low byte wrap sets overflow flag and reloads from high byte.
// - Overflow flag requests interrupt when that timer's interrupt is enabled.
// - Timer 1 auto-reload identical to timer 0, configured with mode code 10 in its own mode field.
// - Counter-select picks prescaled clock ticks or falling edges on count pin.
// - Mode 00 13-bit, 01 16-bit, 10 reload, 11 split/stop.
// - Timer 2 is a 16-bit counter of low and high bytes.
// - Timer 2 clock divides by one or twelve, or counts pin edges.
// - Without baud bits, capture/reload bit picks capture or auto-reload.
// - Baud bits make timer 2 a baud generator, ignoring capture/reload bit.
// - Timer 2 run bit clear stops timer 2 entirely.
// - Capture pin falling edge copies timer 2 count into capture bytes.
// - Timer 2 wrap from all ones sets overflow flag and interrupt, except in baud mode.
// - Captures happen only while external-enable bit is set.
// - Timer 2 provides a trigger to start an analog conversion.
// - Timer 2 interrupt from overflow flag or external flag, own vector.
`default_nettype none
module tcs_timers (
	input  wire logic       sys_clk,
	input  wire logic       reset,
	input  wire logic [7:0] sfr_addr,
	input  wire logic [7:0] sfr_wdata,
	input  wire logic       sfr_wr,
	input  wire logic       sfr_rd,
	output logic      [7:0] sfr_rdata,
	input  wire logic       ext_irq0_pin,
	input  wire logic       ext_irq1_pin,
	input  wire logic       timer0_count_pin,
	input  wire logic       timer1_count_pin,
	input  wire logic       timer2_count_pin,
	input  wire logic       timer2_capture_pin,
	input  wire logic [2:0] timer_irq_enable,
	output logic            timer0_irq,
	output logic            timer1_irq,
	output logic            timer2_irq,
	output logic            timer2_baud_tick,
	output logic            timer2_adc_trigger
);
	tcs_pkg::tcs_state_s s_reg;
	tcs_pkg::tcs_state_s s_next;
	logic [tcs_pkg::PIN_COUNT-1:0] pin_raw;
	logic [tcs_pkg::PIN_COUNT-1:0] pin_level;
	logic [tcs_pkg::PIN_COUNT-1:0] pin_fall;

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: irq0, irq1, count0, count1, count2, capture

	assign pin_raw = {timer2_capture_pin, timer2_count_pin, timer1_count_pin,
		timer0_count_pin, ext_irq1_pin, ext_irq0_pin};

	for (genvar i = 0; i < tcs_pkg::PIN_COUNT; i++) begin : g_sync
		tcs_pin_sync u_sync (
			.sys_clk (sys_clk),
			.reset   (reset),
			.pin     (pin_raw[i]),
			.level   (pin_level[i]),
			.fall    (pin_fall[i])
		);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic tcs_pkg::tcs_step_s step(input logic [1:0] mode,
			input logic [7:0] low, input logic [7:0] high);
		tcs_pkg::tcs_step_s r;
		logic [12:0] c13;
		r = '{ovf: 1'b0, low: low, high: high};
		c13 = {high, low[4:0]};
		unique case (mode)
			tcs_pkg::MODE_13BIT: begin
				r.ovf = (high == tcs_pkg::BYTE_ONES) && (low[4:0] == tcs_pkg::LOW5_ONES);
				c13 = c13 + 13'd1;
				r.low = {low[7:5], c13[4:0]};
				r.high = c13[12:5];
			end
			tcs_pkg::MODE_16BIT: begin
				r.ovf = (high == tcs_pkg::BYTE_ONES) && (low == tcs_pkg::BYTE_ONES);
				{r.high, r.low} = {high, low} + 16'd1;
			end
			tcs_pkg::MODE_RELOAD, tcs_pkg::MODE_SPLIT: begin
				r.ovf = (low == tcs_pkg::BYTE_ONES);
				// Reload on wrap, high byte untouched
				r.low = r.ovf ? high : low + 8'd1;
			end
		endcase
		return r;
	endfunction : step

	function automatic logic src_tick(input logic ct, input logic fast,
			input logic pin_edge, input logic div12);
		return ct ? pin_edge : (fast | div12);
	endfunction : src_tick

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		logic div12;
		logic run0;
		logic run1;
		logic tick0;
		logic tick1;
		logic tick_hi;
		logic tick2;
		logic set_tf0;
		logic set_tf1;
		logic set_tf2;
		logic set_timer2_external_flag;
		logic baud_mode;
		logic t2_wrap;
		logic ext_ev;
		logic [1:0] mode0;
		logic [1:0] mode1;
		logic [15:0] t2_inc;
		tcs_pkg::tcs_step_s st0;
		tcs_pkg::tcs_step_s st1;
		s_next = s_reg;
		s_next.baud_tick = 1'b0;
		s_next.adc_trig = 1'b0;
		set_tf0 = 1'b0;
		set_tf1 = 1'b0;
		set_tf2 = 1'b0;
		set_timer2_external_flag = 1'b0;
		div12 = (s_reg.presc_cnt == tcs_pkg::PRESC_LAST);
		s_next.presc_cnt = div12 ? 4'h0 : s_reg.presc_cnt + 4'h1;
		mode0 = s_reg.tmode[tcs_pkg::T0_MODE_LSB +: 2];
		mode1 = s_reg.tmode[tcs_pkg::T1_MODE_LSB +: 2];
		// Gate qualifies run with the external irq level
		run0 = s_reg.tctrl[tcs_pkg::TR0_BIT]
			& (~s_reg.tmode[tcs_pkg::T0_GATE_BIT] | pin_level[0]);
		run1 = s_reg.tctrl[tcs_pkg::TR1_BIT]
			& (~s_reg.tmode[tcs_pkg::T1_GATE_BIT] | pin_level[1]);
		tick0 = run0 & src_tick(s_reg.tmode[tcs_pkg::T0_CT_BIT],
			s_reg.prescale[tcs_pkg::T0_CLKSEL_BIT], pin_fall[2], div12);
		tick1 = run1 & src_tick(s_reg.tmode[tcs_pkg::T1_CT_BIT],
			s_reg.prescale[tcs_pkg::T1_CLKSEL_BIT], pin_fall[3], div12);
		// Split mode high byte borrows timer 1 run bit, timer 0 clock
		tick_hi = s_reg.tctrl[tcs_pkg::TR1_BIT]
			& (s_reg.prescale[tcs_pkg::T0_CLKSEL_BIT] | div12);

		st0 = step(mode0, s_reg.t0_low, s_reg.t0_high);
		st1 = step(mode1, s_reg.t1_low, s_reg.t1_high);
		if (tick0) begin
			s_next.t0_low = st0.low;
			if (mode0 != tcs_pkg::MODE_SPLIT) begin
				s_next.t0_high = st0.high;
			end else begin
				s_next.t0_low = s_reg.t0_low + 8'd1;
			end
			set_tf0 = st0.ovf;
		end
		if (mode0 == tcs_pkg::MODE_SPLIT && tick_hi) begin
			s_next.t0_high = s_reg.t0_high + 8'd1;
			set_tf1 = (s_reg.t0_high == tcs_pkg::BYTE_ONES);
		end
		// Mode 11 holds timer 1
		if (tick1 && mode1 != tcs_pkg::MODE_SPLIT) begin
			s_next.t1_low = st1.low;
			s_next.t1_high = st1.high;
			set_tf1 = set_tf1 | st1.ovf;
		end

		// Timer 2
		baud_mode = s_reg.t2ctrl[tcs_pkg::RCLK_BIT] | s_reg.t2ctrl[tcs_pkg::TRANSMIT_BAUD_SELECT_BIT];
		tick2 = s_reg.t2ctrl[tcs_pkg::TR2_BIT] & src_tick(s_reg.t2ctrl[tcs_pkg::CT2_BIT],
			s_reg.prescale[tcs_pkg::T2_CLKSEL_BIT], pin_fall[4], div12);
		t2_wrap = tick2 && ({s_reg.t2_high, s_reg.t2_low} == 16'hFFFF);
		t2_inc = {s_reg.t2_high, s_reg.t2_low} + 16'd1;
		ext_ev = s_reg.t2ctrl[tcs_pkg::TR2_BIT] & s_reg.t2ctrl[tcs_pkg::TIMER2_EXTERNAL_ENABLE_BIT]
			& pin_fall[5] & ~baud_mode;
		if (tick2) begin
			{s_next.t2_high, s_next.t2_low} = t2_inc;
		end
		if (t2_wrap) begin
			s_next.adc_trig = 1'b1;
			if (baud_mode) begin
				s_next.baud_tick = 1'b1;
				{s_next.t2_high, s_next.t2_low} = {s_reg.cap_high, s_reg.cap_low};
			end else begin
				set_tf2 = 1'b1;
				if (!s_reg.t2ctrl[tcs_pkg::CPRL_BIT]) begin
					{s_next.t2_high, s_next.t2_low} = {s_reg.cap_high, s_reg.cap_low};
				end
			end
		end
		if (ext_ev) begin
			set_timer2_external_flag = 1'b1;
			if (s_reg.t2ctrl[tcs_pkg::CPRL_BIT]) begin
				s_next.cap_high = s_reg.t2_high;
				s_next.cap_low = s_reg.t2_low;
			end else begin
				{s_next.t2_high, s_next.t2_low} = {s_reg.cap_high, s_reg.cap_low};
			end
		end

		// Software writes override the counters
		if (sfr_wr) begin
			unique case (sfr_addr)
				tcs_pkg::ADDR_TMODE:    s_next.tmode = sfr_wdata;
				tcs_pkg::ADDR_TCTRL:    s_next.tctrl = sfr_wdata;
				tcs_pkg::ADDR_PRESCALE: s_next.prescale = sfr_wdata;
				tcs_pkg::ADDR_T2CTRL:   s_next.t2ctrl = sfr_wdata;
				tcs_pkg::ADDR_T0_LOW:   s_next.t0_low = sfr_wdata;
				tcs_pkg::ADDR_T0_HIGH:  s_next.t0_high = sfr_wdata;
				tcs_pkg::ADDR_T1_LOW:   s_next.t1_low = sfr_wdata;
				tcs_pkg::ADDR_T1_HIGH:  s_next.t1_high = sfr_wdata;
				tcs_pkg::ADDR_T2_LOW:   s_next.t2_low = sfr_wdata;
				tcs_pkg::ADDR_T2_HIGH:  s_next.t2_high = sfr_wdata;
				tcs_pkg::ADDR_CAP_LOW:  s_next.cap_low = sfr_wdata;
				tcs_pkg::ADDR_CAP_HIGH: s_next.cap_high = sfr_wdata;
				default: ;
			endcase
		end
		// Hardware set beats a same-cycle software clear; only software clears
		if (set_tf0) s_next.tctrl[tcs_pkg::TF0_BIT] = 1'b1;
		if (set_tf1) s_next.tctrl[tcs_pkg::TF1_BIT] = 1'b1;
		if (set_tf2) s_next.t2ctrl[tcs_pkg::TF2_BIT] = 1'b1;
		if (set_timer2_external_flag) s_next.t2ctrl[tcs_pkg::TIMER2_EXTERNAL_FLAG_BIT] = 1'b1;

		s_next.rdata = tcs_pkg::RESET_VALUE;
		if (sfr_rd) begin
			unique case (sfr_addr)
				tcs_pkg::ADDR_TMODE:    s_next.rdata = s_reg.tmode;
				tcs_pkg::ADDR_TCTRL:    s_next.rdata = s_reg.tctrl;
				tcs_pkg::ADDR_PRESCALE: s_next.rdata = s_reg.prescale;
				tcs_pkg::ADDR_T2CTRL:   s_next.rdata = s_reg.t2ctrl;
				tcs_pkg::ADDR_T0_LOW:   s_next.rdata = s_reg.t0_low;
				tcs_pkg::ADDR_T0_HIGH:  s_next.rdata = s_reg.t0_high;
				tcs_pkg::ADDR_T1_LOW:   s_next.rdata = s_reg.t1_low;
				tcs_pkg::ADDR_T1_HIGH:  s_next.rdata = s_reg.t1_high;
				tcs_pkg::ADDR_T2_LOW:   s_next.rdata = s_reg.t2_low;
				tcs_pkg::ADDR_T2_HIGH:  s_next.rdata = s_reg.t2_high;
				tcs_pkg::ADDR_CAP_LOW:  s_next.rdata = s_reg.cap_low;
				tcs_pkg::ADDR_CAP_HIGH: s_next.rdata = s_reg.cap_high;
				default: ;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign sfr_rdata          = s_reg.rdata;
	assign timer0_irq         = timer_irq_enable[0] & s_reg.tctrl[tcs_pkg::TF0_BIT];
	assign timer1_irq         = timer_irq_enable[1] & s_reg.tctrl[tcs_pkg::TF1_BIT];
	assign timer2_irq         = timer_irq_enable[2] & (s_reg.t2ctrl[tcs_pkg::TF2_BIT]
		| s_reg.t2ctrl[tcs_pkg::TIMER2_EXTERNAL_FLAG_BIT]);
	assign timer2_baud_tick   = s_reg.baud_tick;
	assign timer2_adc_trigger = s_reg.adc_trig;
endmodule : tcs_timers
`default_nettype wire

/* File: test/tcs_timers_monitor.sv */
`default_nettype none
module tcs_timers_monitor (
	input wire logic       sys_clk,
	input wire logic       reset,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic       sfr_wr,
	input wire logic       sfr_rd,
	input wire logic [7:0] sfr_rdata,
	input wire logic [2:0] timer_irq_enable,
	input wire logic       timer0_irq,
	input wire logic       timer1_irq,
	input wire logic       timer2_irq,
	input wire logic       timer2_baud_tick,
	input wire logic       timer2_adc_trigger
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (reset);
	logic [7:0] mode_q;
	logic       tctrl_wr;
	logic       t2ctrl_wr;
	assign tctrl_wr  = sfr_wr && sfr_addr == tcs_pkg::ADDR_TCTRL;
	assign t2ctrl_wr = sfr_wr && sfr_addr == tcs_pkg::ADDR_T2CTRL;
	// Shadow of the mode register, to judge reads of it
	always_ff @(posedge sys_clk) begin
		if (reset)
			mode_q <= 8'h00;
		else if (sfr_wr && sfr_addr == tcs_pkg::ADDR_TMODE)
			mode_q <= sfr_wdata;
	end
	sequence mode_rd_s;
		sfr_rd && sfr_addr == tcs_pkg::ADDR_TMODE;
	endsequence
	////////////////////////////////////////////////////////////////////////////////
	rdata_idle_a: assert property (!sfr_rd |=> sfr_rdata == 8'h00)
		else $error("read data not zero without a read");
	mode_read_a: assert property (mode_rd_s |=> sfr_rdata == $past(mode_q))
		else $error("mode register read mismatch");
	unmapped_read_a: assert property (sfr_rd && sfr_addr == 8'h00 |=> sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
	irq0_mask_a: assert property (!timer_irq_enable[0] |-> !timer0_irq)
		else $error("timer0 irq while disabled");
	irq1_mask_a: assert property (!timer_irq_enable[1] |-> !timer1_irq)
		else $error("timer1 irq while disabled");
	irq2_mask_a: assert property (!timer_irq_enable[2] |-> !timer2_irq)
		else $error("timer2 irq while disabled");
	irq0_hold_a: assert property ($fell(timer0_irq) |->
		$past(tctrl_wr) || $fell(timer_irq_enable[0]))
		else $error("timer0 flag cleared by hardware");
	irq1_hold_a: assert property ($fell(timer1_irq) |->
		$past(tctrl_wr) || $fell(timer_irq_enable[1]))
		else $error("timer1 flag cleared by hardware");
	irq2_hold_a: assert property ($fell(timer2_irq) |->
		$past(t2ctrl_wr) || $fell(timer_irq_enable[2]))
		else $error("timer2 flag cleared by hardware");
	baud_trig_a: assert property (timer2_baud_tick |-> timer2_adc_trigger)
		else $error("baud tick without wrap trigger");
endmodule : tcs_timers_monitor

bind tcs_timers tcs_timers_monitor tcs_timers_monitor_i (
	.sys_clk(sys_clk), .reset(reset), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
	.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .timer_irq_enable(timer_irq_enable),
	.timer0_irq(timer0_irq), .timer1_irq(timer1_irq), .timer2_irq(timer2_irq),
	.timer2_baud_tick(timer2_baud_tick), .timer2_adc_trigger(timer2_adc_trigger)
);
`default_nettype wire

/* File: test/test_timer_counter_set.sv */
`default_nettype none
module test_timer_counter_set;
	timeunit 1ns;
	timeprecision 1ps;
	logic        sys_clk, reset, sfr_wr, sfr_rd;
	logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, d, v, r, lo, hi;
	logic [5:0]  pins;
	logic [2:0]  irq_en;
	logic [2:0]  irq;
	logic        baud, trig;
	int          n_baud, n_trig;
	logic [8:0]  e;
	logic [31:0] seed;
	int          fails, checks_done;
	logic [7:0]  ra [6];
	tcs_timers tcs_timers_i (.sys_clk(sys_clk), .reset(reset), .sfr_addr(sfr_addr),
		.sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
		.ext_irq0_pin(pins[0]), .ext_irq1_pin(pins[1]), .timer0_count_pin(pins[2]),
		.timer1_count_pin(pins[3]), .timer2_count_pin(pins[4]), .timer2_capture_pin(pins[5]),
		.timer_irq_enable(irq_en), .timer0_irq(irq[0]), .timer1_irq(irq[1]),
		.timer2_irq(irq[2]), .timer2_baud_tick(baud), .timer2_adc_trigger(trig));
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] nxt();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction : nxt
	// Flag in bit 8, low byte after n counts
	function automatic logic [8:0] exp_reload(input logic [7:0] s, input logic [7:0] rl, input int n);
		logic [8:0] x;
		x = {1'b0, s};
		repeat (n) x = (x[7:0] == 8'hFF) ? {1'b1, rl} : {x[8], x[7:0] + 8'h01};
		return x;
	endfunction : exp_reload
	task chk_byte(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_byte
	task chk_bit(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_bit
	task wr(input logic [7:0] a, input logic [7:0] x);
		@(posedge sys_clk);
		sfr_wr <= 1'b1;
		sfr_addr <= a;
		sfr_wdata <= x;
		@(posedge sys_clk);
		sfr_wr <= 1'b0;
		#1;
	endtask : wr
	task rd(input logic [7:0] a);
		@(posedge sys_clk);
		sfr_rd <= 1'b1;
		sfr_addr <= a;
		@(posedge sys_clk);
		sfr_rd <= 1'b0;
		#1 d = sfr_rdata;
	endtask : rd
	// Low and high held 3 cycles each so the synchroniser sees both
	task pulse(input int p, input int n);
		repeat (n) begin
			@(posedge sys_clk);
			pins[p] <= 1'b0;
			repeat (3) @(posedge sys_clk);
			pins[p] <= 1'b1;
			repeat (3) @(posedge sys_clk);
		end
	endtask : pulse
	task end_sim;
		$display("checks=%0d fails=%0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_sim
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// Pulses last one cycle, so count them as they pass
	always @(posedge sys_clk) begin
		if (!reset && baud === 1'b1) n_baud++;
		if (!reset && trig === 1'b1) n_trig++;
	end
	initial begin
		#200000;
		fails++;
		end_sim();
	end
	initial begin
		reset = 1'b1;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		sfr_addr = 8'h00;
		sfr_wdata = 8'h00;
		pins = 6'h3F;
		irq_en = 3'h7;
		seed = 32'h0000_aa9c;
		ra = '{tcs_pkg::ADDR_TMODE, tcs_pkg::ADDR_TCTRL, tcs_pkg::ADDR_T0_LOW,
			tcs_pkg::ADDR_T2CTRL, tcs_pkg::ADDR_CAP_HIGH, 8'h00};
		repeat (20) @(posedge sys_clk);
		reset <= 1'b0;
		foreach (ra[i]) begin
			rd(ra[i]);
			chk_byte(d, tcs_pkg::RESET_VALUE);
		end
		repeat (8) begin
			v = nxt();
			wr(tcs_pkg::ADDR_TMODE, v);
			rd(tcs_pkg::ADDR_TMODE);
			chk_byte(d, v);
		end
		wr(8'h00, 8'h5A);
		rd(8'h00);
		chk_byte(d, 8'h00);
		// Both timers in reload mode, counting pin edges
		wr(tcs_pkg::ADDR_TMODE, 8'h66);
		for (int i = 0; i < 2; i++) begin
			lo = i ? tcs_pkg::ADDR_T1_LOW : tcs_pkg::ADDR_T0_LOW;
			hi = i ? tcs_pkg::ADDR_T1_HIGH : tcs_pkg::ADDR_T0_HIGH;
			r = nxt();
			wr(hi, r);
			wr(lo, 8'hFD);
			wr(tcs_pkg::ADDR_TCTRL, i ? 8'h40 : 8'h10);
			pulse(2 + i, 5);
			e = exp_reload(8'hFD, r, 5);
			rd(lo);
			chk_byte(d, e[7:0]);
			rd(hi);
			chk_byte(d, r);
			chk_bit(irq[i], e[8]);
			@(posedge sys_clk);
			irq_en[i] <= 1'b0;
			@(posedge sys_clk);
			#1 chk_bit(irq[i], 1'b0);
			@(posedge sys_clk);
			irq_en <= 3'h7;
			wr(tcs_pkg::ADDR_TCTRL, 8'h00);
			chk_bit(irq[i], 1'b0);
		end
		// Gate set: edges count only while the gate pin is high
		wr(tcs_pkg::ADDR_TMODE, 8'h0E);
		wr(tcs_pkg::ADDR_T0_LOW, 8'h10);
		wr(tcs_pkg::ADDR_TCTRL, 8'h10);
		pins[0] <= 1'b0;
		pulse(2, 3);
		rd(tcs_pkg::ADDR_T0_LOW);
		chk_byte(d, 8'h10);
		pins[0] <= 1'b1;
		repeat (3) @(posedge sys_clk);
		pulse(2, 2);
		rd(tcs_pkg::ADDR_T0_LOW);
		chk_byte(d, 8'h12);
		// 13-bit mode: five low bits carry into the high byte
		wr(tcs_pkg::ADDR_TMODE, 8'h04);
		wr(tcs_pkg::ADDR_T0_LOW, 8'hFF);
		wr(tcs_pkg::ADDR_T0_HIGH, 8'h00);
		wr(tcs_pkg::ADDR_TCTRL, 8'h10);
		pulse(2, 1);
		rd(tcs_pkg::ADDR_T0_LOW);
		chk_byte(d, 8'hE0);
		rd(tcs_pkg::ADDR_T0_HIGH);
		chk_byte(d, 8'h01);
		wr(tcs_pkg::ADDR_TCTRL, 8'h00);
		// Timer 2 capture: edge ignored until enabled
		wr(tcs_pkg::ADDR_T2_LOW, 8'hFE);
		wr(tcs_pkg::ADDR_T2_HIGH, 8'hFF);
		wr(tcs_pkg::ADDR_T2CTRL, 8'h07);
		pulse(4, 3);
		pulse(5, 1);
		rd(tcs_pkg::ADDR_CAP_LOW);
		chk_byte(d, 8'h00);
		chk_bit(irq[2], 1'b1);
		wr(tcs_pkg::ADDR_T2CTRL, 8'h0F);
		pulse(5, 1);
		rd(tcs_pkg::ADDR_CAP_LOW);
		chk_byte(d, 8'h01);
		rd(tcs_pkg::ADDR_CAP_HIGH);
		chk_byte(d, 8'h00);
		// Baud mode wraps from the capture bytes, no overflow flag
		wr(tcs_pkg::ADDR_T2_LOW, 8'hFF);
		wr(tcs_pkg::ADDR_T2_HIGH, 8'hFF);
		wr(tcs_pkg::ADDR_T2CTRL, 8'h16);
		pulse(4, 1);
		rd(tcs_pkg::ADDR_T2_LOW);
		chk_byte(d, 8'h01);
		rd(tcs_pkg::ADDR_T2CTRL);
		chk_byte(d, 8'h16);
		chk_byte(n_baud[7:0], 8'h01);
		chk_byte(n_trig[7:0], 8'h02);
		// Run bit clear: timer 2 holds
		wr(tcs_pkg::ADDR_T2CTRL, 8'h13);
		pulse(4, 2);
		rd(tcs_pkg::ADDR_T2_LOW);
		chk_byte(d, 8'h01);
		// Auto-reload: wrap reloads from the capture bytes
		wr(tcs_pkg::ADDR_T2_LOW, 8'hFE);
		wr(tcs_pkg::ADDR_T2_HIGH, 8'hFF);
		wr(tcs_pkg::ADDR_T2CTRL, 8'h06);
		pulse(4, 3);
		rd(tcs_pkg::ADDR_T2_LOW);
		chk_byte(d, 8'h02);
		chk_bit(irq[2], 1'b1);
		// System clock, divide by one then twelve; 24 edges in the window
		for (int i = 0; i < 2; i++) begin
			wr(tcs_pkg::ADDR_PRESCALE, i ? 8'h00 : 8'h20);
			wr(tcs_pkg::ADDR_T2_LOW, 8'h00);
			wr(tcs_pkg::ADDR_T2_HIGH, 8'h00);
			wr(tcs_pkg::ADDR_T2CTRL, 8'h05);
			repeat (22) @(posedge sys_clk);
			wr(tcs_pkg::ADDR_T2CTRL, 8'h01);
			rd(tcs_pkg::ADDR_T2_LOW);
			chk_byte(d, i ? 8'h02 : 8'h18);
		end
		chk_byte(n_trig[7:0], 8'h03);
		end_sim();
	end
endmodule : test_timer_counter_set
`default_nettype wire
